// [hdl/ato_core.sv]
/*
  Accumulator transfer unit with an APB register window: software sets the
  accumulator and second nibble register, writes an instruction word, and
  the unit executes it one cycle later into the display control registers,
  the output register or the wide register.
  Assumes an APB3 master on pclk and a display controller that samples the
  display control values when the matching strobe is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ato_regs.svh"

module ato_core #(
  parameter int AW = 12
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output var  logic [31:0]   prdata,
  output var  logic          pready,
  output var  logic          pslverr,
  output var  logic [3:0]    disp_ctrl_one,
  output var  logic [3:0]    disp_ctrl_two,
  output var  logic [3:0]    disp_ctrl_three,
  output var  logic [2:0]    disp_wr,
  output var  logic [2:0]    output_reg,
  output var  logic [7:0]    wide_reg
);

  // =====================================================================
  // apb address decode
  wire [11:0] addr = paddr[11:0];

  wire hit_acc    = (addr == `ATO_OFS_ACC);
  wire hit_breg   = (addr == `ATO_OFS_BREG);
  wire hit_instr  = (addr == `ATO_OFS_INSTR);
  wire hit_carry  = (addr == `ATO_OFS_CARRY);
  wire hit_dc1    = (addr == `ATO_OFS_DC1);
  wire hit_dc2    = (addr == `ATO_OFS_DC2);
  wire hit_dc3    = (addr == `ATO_OFS_DC3);
  wire hit_out    = (addr == `ATO_OFS_OUT);
  wire hit_wide   = (addr == `ATO_OFS_WIDE);
  wire hit_status = (addr == `ATO_OFS_STATUS);
  wire hit_any    = hit_acc | hit_breg | hit_instr | hit_carry | hit_dc1 | hit_dc2 |
                    hit_dc3 | hit_out | hit_wide | hit_status;

  // answer is prepared in setup, so every access completes in one cycle
  wire setup      = psel & ~penable;
  wire access     = psel & penable & pready;
  wire wr_ok      = access & pwrite & hit_any;

  wire wr_acc     = wr_ok & hit_acc;
  wire wr_breg    = wr_ok & hit_breg;
  wire wr_instr   = wr_ok & hit_instr;
  wire wr_carry   = wr_ok & hit_carry;
  wire wr_status  = wr_ok & hit_status;

  // =====================================================================
  // software-visible state
  ato_pkg::ato_nibble_t acc;
  ato_pkg::ato_nibble_t breg;
  logic                 carry_flag;
  logic [9:0]           instr_word;
  logic                 exec_pend;
  logic                 illegal;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc        <= `ATO_RST_NIBBLE;
      breg       <= `ATO_RST_NIBBLE;
      carry_flag <= 1'b0;
      instr_word <= `ATO_RST_OPC;
    end else begin
      if (wr_acc) begin
        acc <= pwdata[3:0];
      end
      if (wr_breg) begin
        breg <= pwdata[3:0];
      end
      if (wr_carry) begin
        carry_flag <= pwdata[0];
      end
      if (wr_instr) begin
        instr_word <= pwdata[9:0];
      end
    end
  end

  // =====================================================================
  // instruction issue and decode
  ato_op_if u_op_if ();

  ato_decode u_decode (
    .opcode (instr_word),
    .valid  (exec_pend),
    .op_bus (u_op_if)
  );

  wire exec    = u_op_if.exec;
  wire ld_dc1  = exec & (u_op_if.op == ato_pkg::ATO_OP_DC1);
  wire ld_dc2  = exec & (u_op_if.op == ato_pkg::ATO_OP_DC2);
  wire ld_dc3  = exec & (u_op_if.op == ato_pkg::ATO_OP_DC3);
  wire ld_out  = exec & (u_op_if.op == ato_pkg::ATO_OP_OUT);
  wire ld_wide = exec & (u_op_if.op == ato_pkg::ATO_OP_WIDE);
  wire is_bad  = exec & (u_op_if.op == ato_pkg::ATO_OP_BAD);

  // set beats a simultaneous write-one-to-clear
  wire next_illegal = is_bad | (illegal & ~(wr_status & pwdata[`ATO_ST_ILLEGAL]));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exec_pend <= 1'b0;
      illegal   <= 1'b0;
    end else begin
      exec_pend <= wr_instr;
      illegal   <= next_illegal;
    end
  end

  // =====================================================================
  // instruction targets
  ato_ld_reg #(.W(4), .RST(`ATO_RST_NIBBLE)) u_dc1 (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld_dc1),
    .d       (acc),
    .q       (disp_ctrl_one)
  );

  ato_ld_reg #(.W(4), .RST(`ATO_RST_NIBBLE)) u_dc2 (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld_dc2),
    .d       (acc),
    .q       (disp_ctrl_two)
  );

  ato_ld_reg #(.W(4), .RST(`ATO_RST_NIBBLE)) u_dc3 (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld_dc3),
    .d       (acc),
    .q       (disp_ctrl_three)
  );

  // only the three low accumulator bits reach the output register
  ato_ld_reg #(.W(3), .RST(`ATO_RST_OUT)) u_out (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld_out),
    .d       (acc[2:0]),
    .q       (output_reg)
  );

  // second register high nibble, accumulator low nibble; carry untouched
  ato_ld_reg #(.W(8), .RST(`ATO_RST_WIDE)) u_wide (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld_wide),
    .d       ({breg, acc}),
    .q       (wide_reg)
  );

  // =====================================================================
  // display controller strobes, aligned with the new register values
  wire [2:0] next_disp_wr = {ld_dc3, ld_dc2, ld_dc1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_wr <= 3'h0;
    end else begin
      disp_wr <= next_disp_wr;
    end
  end

  // =====================================================================
  // read mux and apb answer
  wire [31:0] rd_mux =
    hit_acc    ? {28'h0000000, acc}                          :
    hit_breg   ? {28'h0000000, breg}                         :
    hit_instr  ? {22'h000000, instr_word}                    :
    hit_carry  ? {31'h00000000, carry_flag}                  :
    hit_dc1    ? {28'h0000000, disp_ctrl_one}                :
    hit_dc2    ? {28'h0000000, disp_ctrl_two}                :
    hit_dc3    ? {28'h0000000, disp_ctrl_three}              :
    hit_out    ? {29'h00000000, output_reg}                  :
    hit_wide   ? {24'h000000, wide_reg}                      :
    hit_status ? {30'h00000000, exec_pend, illegal}          :
                 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit_any;
      prdata  <= setup ? rd_mux : 32'h00000000;
    end
  end

  // =====================================================================
  // assertions
  dc1_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_dc1 |=> (disp_ctrl_one == $past(acc)) && $stable(disp_ctrl_two))
    else $error("display control one not loaded from accumulator");

  dc2_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_dc2 |=> (disp_ctrl_two == $past(acc)) && $stable(disp_ctrl_three))
    else $error("display control two not loaded from accumulator");

  dc3_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_dc3 |=> (disp_ctrl_three == $past(acc)) && $stable(disp_ctrl_one))
    else $error("display control three not loaded from accumulator");

  out_low_bits_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_out |=> (output_reg == $past(acc[2:0])) && $stable(wide_reg))
    else $error("output register not loaded from low accumulator bits");

  disp_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(disp_ctrl_one) |-> disp_wr[0] && $past(ld_dc1, 1))
    else $error("display control one changed without its strobe");

  wide_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_wide |=> wide_reg == {$past(breg), $past(acc)})
    else $error("wide register not filled from both nibbles");

  carry_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_wide && !wr_carry) |=> $stable(carry_flag))
    else $error("carry changed by combined load");

  single_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_instr |=> exec_pend ##1 !exec_pend)
    else $error("instruction did not execute in exactly one cycle");

  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready ##1 !pready)
    else $error("apb answer not given in the first access cycle");

  illegal_set_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_bad |=> illegal)
    else $error("unknown instruction not flagged");

  // =====================================================================
  // protocol, refusal and side-effect checks
  apb_write_land_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc |=> acc == $past(pwdata[3:0]))
    else $error("accumulator write did not land");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit_any) |=> pready && pslverr)
    else $error("unmapped access not refused");

  mapped_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && hit_any) |=> pready && !pslverr)
    else $error("mapped access flagged as error");

  rdata_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == 32'h00000000)
    else $error("read data driven outside the access cycle");

  strobe_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
    disp_wr != 3'h0 |=> disp_wr == 3'h0)
    else $error("display strobe wider than one cycle");

  out_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_out |=> $stable({disp_ctrl_one, disp_ctrl_two, disp_ctrl_three}))
    else $error("output load disturbed a display control register");

  wide_only_a: assert property (@(posedge pclk) disable iff (!presetn)
    ld_wide |=> $stable(output_reg) && $stable(disp_ctrl_one))
    else $error("combined load disturbed another target");

  bad_no_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    is_bad |=> $stable({disp_ctrl_one, disp_ctrl_two, disp_ctrl_three})
               && $stable({output_reg, wide_reg}))
    else $error("unknown instruction changed a target register");

  illegal_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_status && pwdata[`ATO_ST_ILLEGAL] && !is_bad) |=> !illegal)
    else $error("illegal flag not cleared by write of one");

  // =====================================================================
  // scenario coverage
  dc_load_c: cover property (@(posedge pclk) disable iff (!presetn)
    ld_dc1 ##2 ld_dc2 ##2 ld_dc3);
  out_load_c: cover property (@(posedge pclk) disable iff (!presetn) ld_out);
  wide_load_c: cover property (@(posedge pclk) disable iff (!presetn) ld_wide);
  ro_write_c: cover property (@(posedge pclk) disable iff (!presetn) wr_ok && hit_dc1);
  bad_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    illegal ##[1:20] !illegal);

endmodule : ato_core

`default_nettype wire

// [hdl/ato_regs.svh]
/*
  Register offsets, reset values and opcodes of the accumulator transfer block.
  Assumes inclusion by bare name from the hdl directory.
*/
`ifndef ATO_REGS_SVH
`define ATO_REGS_SVH

// =====================================================================
// byte offsets on the APB window
`define ATO_OFS_ACC        12'h000
`define ATO_OFS_BREG       12'h004
`define ATO_OFS_INSTR      12'h008
`define ATO_OFS_CARRY      12'h00C
`define ATO_OFS_DC1        12'h010
`define ATO_OFS_DC2        12'h014
`define ATO_OFS_DC3        12'h018
`define ATO_OFS_OUT        12'h01C
`define ATO_OFS_WIDE       12'h020
`define ATO_OFS_STATUS     12'h024

// =====================================================================
// field positions
`define ATO_ST_ILLEGAL     0
`define ATO_ST_PEND        1

// =====================================================================
// reset values
`define ATO_RST_NIBBLE     4'h0
`define ATO_RST_OUT        3'h0
`define ATO_RST_WIDE       8'h00
`define ATO_RST_OPC        10'h000

// =====================================================================
// instruction words
`define ATO_OPC_DC1        10'h2A8
`define ATO_OPC_DC2        10'h2A9
`define ATO_OPC_DC3        10'h216
`define ATO_OPC_OUT        10'h029
`define ATO_OPC_WIDE       10'h01B

// =====================================================================
// timing: every instruction completes in one cycle
`define ATO_EXEC_CYCLES    1

`endif

// [hdl/ato_pkg.sv]
/*
  Types shared by the accumulator transfer block.
  Assumes nothing of its surroundings.
*/
package ato_pkg;

  // =====================================================================
  // decoded operation
  typedef enum logic [2:0] {
    ATO_OP_NONE,
    ATO_OP_DC1,
    ATO_OP_DC2,
    ATO_OP_DC3,
    ATO_OP_OUT,
    ATO_OP_WIDE,
    ATO_OP_BAD
  } ato_op_e;

  typedef logic [3:0] ato_nibble_t;

endpackage : ato_pkg

// [hdl/ato_op_if.sv]
/*
  Carrier of the decoded operation from the decoder to the executing core.
  Assumes ato_pkg is compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

interface ato_op_if;
  logic              exec;
  ato_pkg::ato_op_e  op;

  modport dec (output exec, output op);
  modport exe (input exec, input op);
endinterface : ato_op_if

`default_nettype wire

// [hdl/ato_decode.sv]
/*
  Combinational decoder of the single-word transfer instructions.
  Assumes the opcode is held stable while valid is high.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ato_regs.svh"

module ato_decode (
  input  wire logic [9:0] opcode,
  input  wire logic       valid,
  ato_op_if.dec           op_bus
);

  // =====================================================================
  // opcode match
  wire is_dc1  = (opcode == `ATO_OPC_DC1);
  wire is_dc2  = (opcode == `ATO_OPC_DC2);
  wire is_dc3  = (opcode == `ATO_OPC_DC3);
  wire is_out  = (opcode == `ATO_OPC_OUT);
  wire is_wide = (opcode == `ATO_OPC_WIDE);

  assign op_bus.exec = valid;
  assign op_bus.op   = !valid  ? ato_pkg::ATO_OP_NONE :
                       is_dc1  ? ato_pkg::ATO_OP_DC1  :
                       is_dc2  ? ato_pkg::ATO_OP_DC2  :
                       is_dc3  ? ato_pkg::ATO_OP_DC3  :
                       is_out  ? ato_pkg::ATO_OP_OUT  :
                       is_wide ? ato_pkg::ATO_OP_WIDE :
                                 ato_pkg::ATO_OP_BAD;

endmodule : ato_decode

`default_nettype wire

// [hdl/ato_ld_reg.sv]
/*
  Loadable target register, one per instruction destination.
  Assumes a single clock and an asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module ato_ld_reg #(
  parameter int         W   = 4,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         load,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= RST;
    end else if (load) begin
      q <= d;
    end
  end

endmodule : ato_ld_reg

`default_nettype wire

// [tb/tb_accumulator_transfer_ops.sv]
/*
  Self-checking bench of the accumulator transfer unit: APB tasks, an
  integer model of the target registers, read-back and port checks after every instruction.
  Assumes the hdl files are compiled first, ato_regs.svh on the path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ato_regs.svh"

`define CHK(what, exp, got) begin comparisons++; if ((got) !== (exp)) begin \
  num_errors++; $display("unexpected %s: expected %0h seen %0h", what, exp, got); end end

module tb_accumulator_transfer_ops;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  disp_ctrl_one;
  logic [3:0]  disp_ctrl_two;
  logic [3:0]  disp_ctrl_three;
  logic [2:0]  disp_wr;
  logic [2:0]  output_reg;
  logic [7:0]  wide_reg;
  int          num_errors;
  int          comparisons;
  int          m_acc, m_breg, m_cy, m_dc1, m_dc2, m_dc3, m_out, m_wide, m_ill;
  int          m_wr [3];
  int          seen_wr [3];
  int          exp_wr_q [$];
  int          exp_wr;
  logic [31:0] rd;
  logic        err;
  logic [9:0]  opc [5] = '{`ATO_OPC_DC1, `ATO_OPC_DC2, `ATO_OPC_DC3, `ATO_OPC_OUT, `ATO_OPC_WIDE};

  ato_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .disp_ctrl_one(disp_ctrl_one), .disp_ctrl_two(disp_ctrl_two),
    .disp_ctrl_three(disp_ctrl_three), .disp_wr(disp_wr), .output_reg(output_reg),
    .wide_reg(wide_reg));

  // =====================================================================
  // clock, strobe monitor, watchdog
  always #12.5 pclk = ~pclk;

  // a strobe held two cycles counts twice and so shows up as a mismatch
  always @(posedge pclk) begin
    for (int i = 0; i < 3; i++) if (disp_wr[i] === 1'b1) seen_wr[i]++;
    if (disp_wr !== 3'h0) begin
      exp_wr = (exp_wr_q.size() > 0) ? exp_wr_q.pop_front() : 0;
      `CHK("strobe order", exp_wr, disp_wr)
    end
  end

  initial begin
    #(25 * 20000);
    num_errors++;
    give_verdict();
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // =====================================================================
  // apb master: request held until pready is seen at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        num_errors++;
        give_verdict();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rchk(input string what, input logic [11:0] a, input int exp);
    apb(1'b0, a, 32'h0);
    `CHK(what, exp, rd)
  endtask : rchk

  task automatic check_targets();
    rchk("dc1", `ATO_OFS_DC1, m_dc1);
    rchk("dc2", `ATO_OFS_DC2, m_dc2);
    rchk("dc3", `ATO_OFS_DC3, m_dc3);
    rchk("out", `ATO_OFS_OUT, m_out);
    rchk("wide", `ATO_OFS_WIDE, m_wide);
    rchk("carry", `ATO_OFS_CARRY, m_cy);
    rchk("status", `ATO_OFS_STATUS, m_ill);
    `CHK("disp port", m_dc1 | m_dc2 << 4 | m_dc3 << 8, {disp_ctrl_three, disp_ctrl_two, disp_ctrl_one})
    `CHK("out port", m_out, output_reg)
    `CHK("wide port", m_wide, wide_reg)
    for (int i = 0; i < 3; i++) `CHK("strobes", m_wr[i], seen_wr[i])
  endtask : check_targets

  task automatic exec(input logic [9:0] op);
    apb(1'b1, `ATO_OFS_INSTR, {$urandom} & 32'hFFFF_FC00 | op);
    case (op)
      `ATO_OPC_DC1: begin m_dc1 = m_acc; m_wr[0]++; exp_wr_q.push_back(1); end
      `ATO_OPC_DC2: begin m_dc2 = m_acc; m_wr[1]++; exp_wr_q.push_back(2); end
      `ATO_OPC_DC3: begin m_dc3 = m_acc; m_wr[2]++; exp_wr_q.push_back(4); end
      `ATO_OPC_OUT: m_out = m_acc & 7;
      `ATO_OPC_WIDE: m_wide = m_breg << 4 | m_acc;
      default: m_ill = 1;
    endcase
    check_targets();
  endtask : exec

  // =====================================================================
  // main sequence
  initial begin
    logic [31:0] d;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h7b76));
    check_targets();
    $display("test reset done");
    for (int k = 0; k < 15; k++) begin
      d = $urandom;
      apb(1'b1, `ATO_OFS_ACC, d);
      m_acc = d[3:0];
      rchk("acc", `ATO_OFS_ACC, m_acc);
      d = $urandom;
      apb(1'b1, `ATO_OFS_BREG, d);
      m_breg = d[3:0];
      m_cy = $urandom % 2;
      apb(1'b1, `ATO_OFS_CARRY, m_cy);
      exec(opc[k % 5]);
    end
    $display("test transfers done");
    exec(10'h3FF);
    apb(1'b1, `ATO_OFS_STATUS, 32'h1);
    m_ill = 0;
    check_targets();
    $display("test illegal done");
    apb(1'b1, `ATO_OFS_DC1, 32'hF);
    `CHK("ro err", 1'b0, err)
    apb(1'b1, 12'h100, 32'h5);
    `CHK("unmapped err", 1'b1, err)
    rchk("unmapped rd", 12'h100, 0);
    check_targets();
    $display("test access done");
    give_verdict();
  end
endmodule : tb_accumulator_transfer_ops

`default_nettype wire
